// ===== hdl/crdm_core.sv
`timescale 1ns/1ps
module crdm_core import crdm_pkg::*; (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic ARST_N,
	// Operand read and write-back
	input wire logic [RA_W-1:0] RD_ADDR_A,
	input wire logic [RA_W-1:0] RD_ADDR_B,
	input wire logic IMM_OP,
	output logic [DW-1:0] OPERAND_A,
	output logic [DW-1:0] OPERAND_B,
	input wire logic WR_EN,
	input wire logic [RA_W-1:0] WR_ADDR,
	input wire logic [DW-1:0] WR_DATA,
	// Data space access
	input wire logic MEM_REQ,
	input wire logic MEM_WRITE,
	input wire crdm_mode_e MEM_MODE,
	input wire logic [1:0] MEM_PTR,
	input wire logic [5:0] MEM_DISP,
	input wire logic [DA_W-1:0] MEM_DIRECT,
	input wire logic [5:0] MEM_IO_ADDR,
	input wire logic [DW-1:0] MEM_WDATA,
	output logic [DW-1:0] MEM_RDATA,
	output logic MEM_DONE,
	// Peripheral I/O bus
	output logic [5:0] IO_ADDR,
	output logic IO_RE,
	output logic IO_WE,
	output logic [DW-1:0] IO_WDATA,
	input wire logic [DW-1:0] IO_RDATA,
	// Program fetch and flow
	output logic [PC_W-1:0] PROG_ADDR,
	input wire logic [15:0] PROG_DATA,
	output logic [15:0] INSTR,
	output logic INSTR_VALID,
	input wire logic PC_LOAD,
	input wire logic [PC_W-1:0] PC_TARGET,
	input wire logic CALL_REQ,
	input wire logic [PC_W-1:0] CALL_TARGET,
	input wire logic RET_REQ,
	output logic BUSY,
	// Interrupts
	input wire logic [NUM_IRQ-1:0] IRQ,
	output logic [NUM_IRQ-1:0] IRQ_ACK,
	output logic GLOBAL_IE,
	// Flash store and table load
	input wire logic [1:0] BOOT_SIZE_SEL,
	input wire logic [1:0] APP_LOCK,
	input wire logic [1:0] BOOT_LOCK,
	input wire logic SPM_REQ,
	input wire logic TBL_REQ,
	output logic SPM_GRANT,
	output logic TBL_GRANT,
	output logic FLASH_DENY,
	output logic [TA_W-1:0] FLASH_ADDR
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	crdm_state_e state_r, state_nxt;
	logic [DW-1:0] rf [NUM_REGS];
	logic [DW-1:0] sram_r [SRAM_DEPTH];
	logic [PC_W-1:0] pc_r, ret_pc_r, tgt_r;
	logic [PC_W-9:0] ret_hi_r;
	logic [SP_W-1:0] sp_r;
	logic [DW-1:0] sreg_r, acc_wdata_r, opa_r, opb_r, rdata_r, io_wdata_r;
	logic [DA_W-1:0] acc_addr_r;
	logic acc_we_r, busy_r, done_r, io_re_r, io_we_r, valid_r;
	logic spm_r, tbl_r, deny_r;
	logic [5:0] io_addr_r;
	logic [15:0] instr_r;
	logic [NUM_IRQ-1:0] ack_r, irq_pick;
	logic [PC_W-1:0] irq_vec;
	logic [TA_W-1:0] flash_addr_r;
	logic [DA_W-1:0] agu_addr, agu_ptr_new;
	logic agu_ptr_we;

	// ----------------------------------------
	// Request arbitration
	// ----------------------------------------
	wire idle = (state_r == S_IDLE);
	wire ret_go = idle && RET_REQ;
	wire call_go = idle && !RET_REQ && CALL_REQ;
	wire acc_go = idle && !RET_REQ && !CALL_REQ && MEM_REQ;
	// Interrupts only between requests, so a decoder access is never split
	wire irq_take = idle && !RET_REQ && !CALL_REQ && !MEM_REQ && sreg_r[SREG_IE] && (|IRQ);
	wire pushing = (state_r == S_PUSH_LO) || (state_r == S_PUSH_HI);
	wire popping = (state_r == S_POP_HI) || (state_r == S_POP_LO);

	// Lowest index is the lowest vector address
	always_comb begin
		irq_pick = '0;
		irq_vec = PC_RST;
		for (int k = NUM_IRQ - 1; k >= 0; k--) begin
			if (IRQ[k]) begin
				irq_pick = NUM_IRQ'(1) << k;
				irq_vec = VEC_STRIDE * PC_W'(k);
			end
		end
	end

	// ----------------------------------------
	// Pointers and address generation
	// ----------------------------------------
	wire [RA_W-1:0] ptr_lo_idx = PTR_BASE + {2'h0, MEM_PTR, 1'b0};
	wire [RA_W-1:0] ptr_hi_idx = ptr_lo_idx + 5'h01;
	wire [DA_W-1:0] ptr_val = {rf[ptr_hi_idx], rf[ptr_lo_idx]};
	wire ptr_we = acc_go && agu_ptr_we;
	wire [DA_W-1:0] z_val = {rf[NUM_REGS-1], rf[NUM_REGS-2]};

	crdm_agu u_agu (
		.mode(MEM_MODE),
		.ptr_sel(MEM_PTR),
		.ptr_val(ptr_val),
		.disp(MEM_DISP),
		.direct(MEM_DIRECT),
		.io_addr(MEM_IO_ADDR),
		.addr(agu_addr),
		.ptr_we(agu_ptr_we),
		.ptr_new(agu_ptr_new)
	);

	// ----------------------------------------
	// Data space decode
	// ----------------------------------------
	wire [SP_W-1:0] sp_inc = sp_r + 11'h001;
	wire [SP_W-1:0] sp_dec = sp_r - 11'h001;
	wire [DA_W-1:0] ds_addr = (state_r == S_ACC) ? acc_addr_r :
		popping ? {5'h00, sp_inc} : {5'h00, sp_r};
	wire ds_we = ((state_r == S_ACC) && acc_we_r) || pushing;
	wire [DW-1:0] ds_wdata = (state_r == S_ACC) ? acc_wdata_r :
		(state_r == S_PUSH_LO) ? ret_pc_r[DW-1:0] : {3'h0, ret_pc_r[PC_W-1:DW]};
	wire ds_reg = ds_addr < IO_BASE;
	wire ds_io = !ds_reg && (ds_addr < SRAM_BASE);
	wire ds_sram = (ds_addr >= SRAM_BASE) && (ds_addr <= SRAM_TOP);
	wire ds_none = ds_addr > SRAM_TOP;
	wire [DA_W-1:0] ds_io_full = ds_addr - IO_BASE;
	wire [5:0] ds_io_off = ds_io_full[5:0];
	wire [DA_W-1:0] ds_sram_full = ds_addr - SRAM_BASE;
	wire [SRAM_AW-1:0] sram_idx = ds_sram_full[SRAM_AW-1:0];
	wire io_spl = ds_io && (ds_io_off == IO_SPL);
	wire io_sph = ds_io && (ds_io_off == IO_SPH);
	wire io_sreg = ds_io && (ds_io_off == IO_SREG);
	wire [DW-1:0] io_rd = io_spl ? sp_r[DW-1:0] : io_sph ? {5'h00, sp_r[SP_W-1:DW]} :
		io_sreg ? sreg_r : IO_RDATA;
	wire [DW-1:0] ds_rdata = ds_reg ? rf[ds_addr[RA_W-1:0]] : ds_io ? io_rd :
		ds_sram ? sram_r[sram_idx] : 8'h00;

	// Peripheral side of a request, decided at accept
	wire [DA_W-1:0] agu_io_full = agu_addr - IO_BASE;
	wire [5:0] agu_io_off = agu_io_full[5:0];
	wire agu_io = (agu_addr >= IO_BASE) && (agu_addr < SRAM_BASE);
	wire agu_ext = agu_io && (agu_io_off != IO_SPL) && (agu_io_off != IO_SPH) && (agu_io_off != IO_SREG);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Immediate forms see only the upper half
	wire [RA_W-1:0] a_eff = IMM_OP ? {1'b1, RD_ADDR_A[RA_W-2:0]} : RD_ADDR_A;
	wire [RA_W-1:0] wr_eff = IMM_OP ? {1'b1, WR_ADDR[RA_W-2:0]} : WR_ADDR;

	// Write-back beats a data store, which beats a pointer update
	generate
		for (genvar i = 0; i < NUM_REGS; i++) begin : g_rf
			logic [DW-1:0] q_r;
			wire alu_hit = WR_EN && (wr_eff == RA_W'(i));
			wire ds_hit = ds_we && ds_reg && (ds_addr[RA_W-1:0] == RA_W'(i));
			wire plo_hit = ptr_we && (ptr_lo_idx == RA_W'(i));
			wire phi_hit = ptr_we && (ptr_hi_idx == RA_W'(i));
			always_ff @(posedge CLOCK or negedge ARST_N) begin
				if (!ARST_N) begin
					q_r <= 8'h00;
				end else if (alu_hit) begin
					q_r <= WR_DATA;
				end else if (ds_hit) begin
					q_r <= ds_wdata;
				end else if (plo_hit) begin
					q_r <= agu_ptr_new[DW-1:0];
				end else if (phi_hit) begin
					q_r <= agu_ptr_new[DA_W-1:DW];
				end
			end
			assign rf[i] = q_r;
		end
	endgenerate

	// Two operands each clock, captured for the ALU
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			opa_r <= 8'h00;
			opb_r <= 8'h00;
		end else begin
			opa_r <= rf[a_eff];
			opb_r <= rf[RD_ADDR_B];
		end
	end

	// SRAM storage, no reset: contents are undefined at power-up
	always_ff @(posedge CLOCK) begin
		if (ds_we && ds_sram) begin
			sram_r[sram_idx] <= ds_wdata;
		end
	end

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE: begin
				if (ret_go) begin
					state_nxt = S_POP_HI;
				end else if (call_go || irq_take) begin
					state_nxt = S_PUSH_LO;
				end else if (acc_go) begin
					state_nxt = S_ACC;
				end
			end
			S_ACC: state_nxt = S_IDLE;
			S_PUSH_LO: state_nxt = S_PUSH_HI;
			S_PUSH_HI: state_nxt = S_IDLE;
			S_POP_HI: state_nxt = S_POP_LO;
			S_POP_LO: state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
	end

	// Sequencer state and latched request
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_r <= S_IDLE;
			busy_r <= 1'b0;
			acc_addr_r <= '0;
			acc_we_r <= 1'b0;
			acc_wdata_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			busy_r <= (state_nxt != S_IDLE);
			if (acc_go) begin
				acc_addr_r <= agu_addr;
				acc_we_r <= MEM_WRITE;
				acc_wdata_r <= MEM_WDATA;
			end
		end
	end

	// Return and target addresses
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			ret_pc_r <= PC_RST;
			tgt_r <= PC_RST;
			ret_hi_r <= '0;
		end else if (call_go) begin
			ret_pc_r <= pc_r;
			tgt_r <= CALL_TARGET;
		end else if (irq_take) begin
			ret_pc_r <= pc_r - PC_W'(valid_r); // Refetch the dropped prefetch
			tgt_r <= irq_vec;
		end else if (state_r == S_POP_HI) begin
			ret_hi_r <= ds_rdata[PC_W-DW-1:0];
		end
	end

	// Read answer and peripheral strobes
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			done_r <= 1'b0;
			rdata_r <= 8'h00;
			io_re_r <= 1'b0;
			io_we_r <= 1'b0;
			io_addr_r <= 6'h00;
			io_wdata_r <= 8'h00;
			ack_r <= '0;
		end else begin
			done_r <= (state_r == S_ACC);
			if ((state_r == S_ACC) && !acc_we_r) begin
				rdata_r <= ds_rdata;
			end
			io_re_r <= acc_go && agu_ext && !MEM_WRITE;
			io_we_r <= acc_go && agu_ext && MEM_WRITE;
			if (acc_go) begin
				io_addr_r <= agu_io_off;
				io_wdata_r <= MEM_WDATA;
			end
			ack_r <= irq_take ? irq_pick : '0;
		end
	end

	// Stack pointer and status; push/pop steps beat an I/O write
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			sp_r <= SP_RST;
			sreg_r <= SREG_RST;
		end else begin
			if (pushing) begin
				sp_r <= sp_dec;
			end else if (popping) begin
				sp_r <= sp_inc;
			end else if (ds_we && io_spl) begin
				sp_r[DW-1:0] <= ds_wdata;
			end else if (ds_we && io_sph) begin
				sp_r[SP_W-1:DW] <= ds_wdata[SP_W-DW-1:0];
			end
			if (irq_take) begin
				sreg_r[SREG_IE] <= 1'b0;
			end else if (ds_we && io_sreg) begin
				sreg_r <= ds_wdata;
			end
		end
	end

	// ----------------------------------------
	// Fetch pipeline
	// ----------------------------------------
	// Every word is fetched alike; second words of long forms pass through
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			pc_r <= PC_RST;
			instr_r <= 16'h0000;
			valid_r <= 1'b0;
		end else if (state_r == S_POP_LO) begin
			pc_r <= {ret_hi_r, ds_rdata};
			valid_r <= 1'b0;
		end else if (state_r == S_PUSH_HI) begin
			pc_r <= tgt_r;
			valid_r <= 1'b0;
		end else if (!idle) begin
			valid_r <= 1'b0;
		end else if (PC_LOAD) begin
			pc_r <= PC_TARGET;
			valid_r <= 1'b0;
		end else begin
			pc_r <= pc_r + 13'h0001;
			instr_r <= PROG_DATA;
			valid_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// Flash store and table load guard
	// ----------------------------------------
	wire [TA_W-1:0] boot_words = BOOT_MIN_WORDS << BOOT_SIZE_SEL;
	wire [TA_W-1:0] boot_start = PROG_WORDS - boot_words;
	wire in_boot = {1'b0, pc_r} >= boot_start;
	wire tgt_boot = {1'b0, z_val[TA_W-1:1]} >= boot_start;
	wire spm_ok = in_boot && (tgt_boot ? !BOOT_LOCK[LOCK_WP] : !APP_LOCK[LOCK_WP]);
	wire tbl_ok = (in_boot == tgt_boot) || (tgt_boot ? !BOOT_LOCK[LOCK_RP] : !APP_LOCK[LOCK_RP]);

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			spm_r <= 1'b0;
			tbl_r <= 1'b0;
			deny_r <= 1'b0;
			flash_addr_r <= '0;
		end else begin
			spm_r <= SPM_REQ && spm_ok;
			tbl_r <= TBL_REQ && tbl_ok;
			deny_r <= (SPM_REQ && !spm_ok) || (TBL_REQ && !tbl_ok);
			if (SPM_REQ || TBL_REQ) begin
				flash_addr_r <= z_val[TA_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign OPERAND_A = opa_r;
	assign OPERAND_B = opb_r;
	assign MEM_RDATA = rdata_r;
	assign MEM_DONE = done_r;
	assign IO_ADDR = io_addr_r;
	assign IO_RE = io_re_r;
	assign IO_WE = io_we_r;
	assign IO_WDATA = io_wdata_r;
	assign PROG_ADDR = pc_r;
	assign INSTR = instr_r;
	assign INSTR_VALID = valid_r;
	assign BUSY = busy_r;
	assign IRQ_ACK = ack_r;
	assign GLOBAL_IE = sreg_r[SREG_IE];
	assign SPM_GRANT = spm_r;
	assign TBL_GRANT = tbl_r;
	assign FLASH_DENY = deny_r;
	assign FLASH_ADDR = flash_addr_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_imm_upper: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		IMM_OP |=> opa_r == rf[{1'b1, $past(RD_ADDR_A[RA_W-2:0])}] || $past(WR_EN) || $past(ds_we))
		else $error("immediate operand not from upper half");
	a_mem_two_cycle: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		acc_go |=> !done_r ##1 done_r ##1 !done_r)
		else $error("data access not two cycles");
	a_unmapped_zero: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		(state_r == S_ACC && !acc_we_r && ds_none) |=> rdata_r == 8'h00)
		else $error("unmapped read not zero");
	a_postinc_ptr: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		(acc_go && MEM_MODE == M_POSTINC && !WR_EN) |=>
		acc_addr_r == $past(ptr_val) && ptr_val == $past(ptr_val) + ONE16)
		else $error("post-increment wrong");
	a_predec_ptr: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		(acc_go && MEM_MODE == M_PREDEC && !WR_EN) |=>
		acc_addr_r == $past(ptr_val) - ONE16 && ptr_val == acc_addr_r)
		else $error("pre-decrement wrong");
	a_pc_step: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		(idle && !PC_LOAD) |=> pc_r == $past(pc_r) + 13'h0001 && valid_r && instr_r == $past(PROG_DATA))
		else $error("prefetch did not advance");
	a_irq_vector: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		irq_take |=> ##2 pc_r == $past(irq_vec, 3) && !sreg_r[SREG_IE])
		else $error("wrong interrupt vector");
	a_ie_gate: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		(|ack_r) |-> $past(sreg_r[SREG_IE]) && $onehot(ack_r))
		else $error("interrupt taken while disabled");
	a_spm_boot: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		spm_r |-> $past(in_boot) && $past(SPM_REQ))
		else $error("flash store outside boot");
	a_stack_push: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		(state_r == S_PUSH_LO) |-> ##2 sp_r == $past(sp_r, 2) - 11'h002)
		else $error("stack pointer not moved by push");
endmodule : crdm_core

// ===== hdl/crdm_pkg.sv
package crdm_pkg;
	// ----------------------------------------
	// Widths and sizes
	// ----------------------------------------
	localparam int NUM_REGS = 32;
	localparam int RA_W = 5;
	localparam int DW = 8;
	localparam int PC_W = 13;
	localparam int SP_W = 11;
	localparam int DA_W = 16;
	localparam int TA_W = 14;
	localparam int SRAM_DEPTH = 1024;
	localparam int SRAM_AW = 10;
	localparam int NUM_IRQ = 8;
	localparam int SREG_IE = 7;
	localparam int LOCK_WP = 0;
	localparam int LOCK_RP = 1;

	// ----------------------------------------
	// Data space map
	// ----------------------------------------
	localparam logic [DA_W-1:0] IO_BASE = 16'h0020;
	localparam logic [DA_W-1:0] SRAM_BASE = 16'h0060;
	localparam logic [DA_W-1:0] SRAM_TOP = 16'h045f;
	localparam logic [DA_W-1:0] ONE16 = 16'h0001;
	localparam logic [RA_W-1:0] PTR_BASE = 5'h1a;
	localparam logic [1:0] PTR_X = 2'h0;
	localparam logic [1:0] PTR_Y = 2'h1;
	localparam logic [1:0] PTR_Z = 2'h2;
	localparam logic [5:0] IO_SPL = 6'h3d;
	localparam logic [5:0] IO_SPH = 6'h3e;
	localparam logic [5:0] IO_SREG = 6'h3f;

	// ----------------------------------------
	// Program side and reset values
	// ----------------------------------------
	localparam logic [PC_W-1:0] VEC_STRIDE = 13'h0002;
	localparam logic [TA_W-1:0] PROG_WORDS = 14'h2000;
	localparam logic [TA_W-1:0] BOOT_MIN_WORDS = 14'h0080;
	localparam logic [PC_W-1:0] PC_RST = 13'h0000;
	localparam logic [SP_W-1:0] SP_RST = 11'h000;
	localparam logic [DW-1:0] SREG_RST = 8'h00;

	typedef enum logic [2:0] {M_DIRECT, M_IO, M_IND, M_DISP, M_PREDEC, M_POSTINC} crdm_mode_e;
	typedef enum logic [2:0] {S_IDLE, S_ACC, S_PUSH_LO, S_PUSH_HI, S_POP_HI, S_POP_LO} crdm_state_e;
endpackage : crdm_pkg

// ===== hdl/crdm_agu.sv
`timescale 1ns/1ps
module crdm_agu import crdm_pkg::*; (
	// Request
	input wire crdm_mode_e mode,
	input wire logic [1:0] ptr_sel,
	input wire logic [DA_W-1:0] ptr_val,
	input wire logic [5:0] disp,
	input wire logic [DA_W-1:0] direct,
	input wire logic [5:0] io_addr,
	// Result
	output logic [DA_W-1:0] addr,
	output logic ptr_we,
	output logic [DA_W-1:0] ptr_new
);
	// ----------------------------------------
	// Address arithmetic
	// ----------------------------------------
	wire [DA_W-1:0] ptr_inc = ptr_val + ONE16;
	wire [DA_W-1:0] ptr_dec = ptr_val - ONE16;
	// Displacement rides on every pointer select but X, which gets none
	wire [5:0] disp_eff = (ptr_sel == PTR_X) ? 6'h00 : disp;
	wire [DA_W-1:0] disp_sum = ptr_val + {10'h000, disp_eff};

	// Mode select
	always_comb begin
		addr = direct;
		ptr_we = 1'b0;
		ptr_new = ptr_val;
		case (mode)
			M_DIRECT: addr = direct;
			M_IO: addr = IO_BASE + {10'h000, io_addr};
			M_IND: addr = ptr_val;
			M_DISP: addr = disp_sum;
			M_PREDEC: begin
				addr = ptr_dec;
				ptr_we = 1'b1;
				ptr_new = ptr_dec;
			end
			M_POSTINC: begin
				addr = ptr_val;
				ptr_we = 1'b1;
				ptr_new = ptr_inc;
			end
			default: addr = direct;
		endcase
	end
endmodule : crdm_agu

// ===== bench/crdm_far_model.sv
`timescale 1ns/1ps
module crdm_far_model import crdm_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Program memory
	input wire logic [PC_W-1:0] prog_addr,
	output logic [15:0] prog_data,
	// Peripheral bus
	input wire logic [5:0] io_addr,
	input wire logic io_re,
	input wire logic io_we,
	input wire logic [DW-1:0] io_wdata,
	output logic [DW-1:0] io_rdata,
	output logic [15:0] last_wr
);
	logic [DW-1:0] junk_r;
	// ----------------------------------------
	// Answers
	// ----------------------------------------
	// Word pattern tied to its own address
	assign prog_data = {3'h5, prog_addr};
	// Bus not read: churn so stale data never looks valid
	assign io_rdata = io_re ? {2'h3, io_addr} : junk_r;
	// Idle churn and write capture
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			junk_r <= 8'h5a;
			last_wr <= 16'h0000;
		end else begin
			junk_r <= ~junk_r;
			if (io_we) begin
				last_wr <= {2'h0, io_addr, io_wdata};
			end
		end
	end
endmodule : crdm_far_model

// ===== bench/cpu_regfile_and_data_map_bench.sv
`timescale 1ns/1ps
module cpu_regfile_and_data_map_bench import crdm_pkg::*;;
	logic clk = 0, arst_n = 0, imm = 0, wr_en = 0, mreq = 0, mwr = 0, tbl = 0;
	logic [RA_W-1:0] ra = 0, rb = 0, wa = 0;
	logic [DW-1:0] wd = 0, mwd = 0, opa, opb, mrd, io_wd, io_rd;
	crdm_mode_e mmode = M_DIRECT;
	logic [1:0] mptr = 0;
	logic [5:0] mdisp = 0, mio = 0, io_a;
	logic [DA_W-1:0] mdir = 0;
	logic [15:0] pdata, instr, last_wr, got;
	logic [PC_W-1:0] paddr;
	logic [PC_W-1:0] ctgt = 0, pc0;
	logic [NUM_IRQ-1:0] irq = 0, ack;
	logic done, io_re, io_we, ivalid, tgrant, busy, gie, sgrant, deny, creq = 0, rreq = 0, sreq = 0;
	logic [TA_W-1:0] faddr;
	int fails = 0, n_tests = 0, cycles = 0;
	// ----------------------------------------
	// Clock, timeout, instances
	// ----------------------------------------
	initial begin
		forever #20 clk = ~clk;
	end
	// Generous ceiling; the run needs about 120 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			stop_test();
		end
	end
	crdm_core u_crdm_core (.CLOCK(clk), .ARST_N(arst_n), .RD_ADDR_A(ra), .RD_ADDR_B(rb), .IMM_OP(imm),
		.OPERAND_A(opa), .OPERAND_B(opb), .WR_EN(wr_en), .WR_ADDR(wa), .WR_DATA(wd), .MEM_REQ(mreq),
		.MEM_WRITE(mwr), .MEM_MODE(mmode), .MEM_PTR(mptr), .MEM_DISP(mdisp), .MEM_DIRECT(mdir),
		.MEM_IO_ADDR(mio), .MEM_WDATA(mwd), .MEM_RDATA(mrd), .MEM_DONE(done), .IO_ADDR(io_a), .IO_RE(io_re),
		.IO_WE(io_we), .IO_WDATA(io_wd), .IO_RDATA(io_rd), .PROG_ADDR(paddr), .PROG_DATA(pdata), .INSTR(instr),
		.INSTR_VALID(ivalid), .PC_LOAD(1'b0), .PC_TARGET(13'h0000), .CALL_REQ(creq), .CALL_TARGET(ctgt),
		.RET_REQ(rreq), .BUSY(busy), .IRQ(irq), .IRQ_ACK(ack), .GLOBAL_IE(gie), .BOOT_SIZE_SEL(2'h0),
		.APP_LOCK(2'h0), .BOOT_LOCK(2'h0), .SPM_REQ(sreq), .TBL_REQ(tbl), .SPM_GRANT(sgrant), .TBL_GRANT(tgrant),
		.FLASH_DENY(deny),
		.FLASH_ADDR(faddr));
	crdm_far_model u_crdm_far_model (.clk(clk), .arst_n(arst_n), .prog_addr(paddr), .prog_data(pdata),
		.io_addr(io_a), .io_re(io_re), .io_we(io_we), .io_wdata(io_wd), .io_rdata(io_rd), .last_wr(last_wr));
	// ----------------------------------------
	// Shared tasks; all enter and leave at a falling edge
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test
	// Extra falling edge at the end keeps strobes from toggling twice in one step
	task automatic wreg(input logic [4:0] a, input logic [7:0] d);
		wr_en = 1;
		wa = a;
		wd = d;
		@(negedge clk);
		wr_en = 0;
		@(negedge clk);
	endtask : wreg
	task automatic rreg(input logic [4:0] a, input logic [7:0] exp);
		ra = a;
		@(negedge clk);
		chk({8'h00, opa}, {8'h00, exp});
	endtask : rreg
	task automatic mop(input logic w, input crdm_mode_e m, input logic [1:0] p, input logic [5:0] ds,
		input logic [15:0] a, input logic [7:0] d);
		mreq = 1;
		mwr = w;
		mmode = m;
		mptr = p;
		mdisp = ds;
		mdir = a;
		mio = a[5:0];
		mwd = d;
		@(negedge clk);
		mreq = 0;
		@(negedge clk);
		chk({15'h0000, done}, 16'h0001);
		got = {8'h00, mrd};
		@(negedge clk);
	endtask : mop
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_fetch();
		repeat (3) @(negedge clk);
		chk({15'h0000, ivalid}, 16'h0001);
		chk({3'h0, paddr}, 16'h0003);
		chk(instr, 16'ha002);
	endtask : t_fetch
	task automatic t_regs();
		wreg(5'h13, 8'h42);
		imm = 1;
		rreg(5'h03, 8'h42);
		imm = 0;
		mop(1, M_DIRECT, 0, 0, 16'h0003, 8'h99);
		rreg(5'h03, 8'h99);
		rb = 5'h13;
		@(negedge clk);
		chk({8'h00, opb}, 16'h0042);
	endtask : t_regs
	task automatic t_ptr();
		wreg(5'h1a, 8'h60);
		wreg(5'h1b, 8'h00);
		mop(1, M_POSTINC, PTR_X, 0, 0, 8'ha5);
		rreg(5'h1a, 8'h61);
		mop(1, M_PREDEC, PTR_X, 0, 0, 8'h3c);
		mop(0, M_DIRECT, 0, 0, 16'h0060, 0);
		chk(got, 16'h003c);
		mop(0, M_DIRECT, 0, 0, 16'h001a, 0);
		chk(got, 16'h0060);
	endtask : t_ptr
	task automatic t_edges();
		mop(1, M_DIRECT, 0, 0, 16'h045f, 8'h77);
		mop(1, M_DIRECT, 0, 0, 16'h0460, 8'h11);
		mop(0, M_DIRECT, 0, 0, 16'h0460, 0);
		chk(got, 16'h0000);
		mop(0, M_DIRECT, 0, 0, 16'h0060, 0);
		chk(got, 16'h003c);
		mop(0, M_DIRECT, 0, 0, 16'h045f, 0);
		chk(got, 16'h0077);
		wreg(5'h1c, 8'h60);
		wreg(5'h1d, 8'h00);
		mop(1, M_DIRECT, 0, 0, 16'h009f, 8'hc3);
		mop(0, M_DISP, PTR_Y, 6'h3f, 0, 0);
		chk(got, 16'h00c3);
	endtask : t_edges
	task automatic t_io();
		mop(0, M_IO, 0, 0, 16'h0005, 0);
		chk(got, 16'h00c5);
		mop(1, M_DIRECT, 0, 0, 16'h0025, 8'h6e);
		chk(last_wr, 16'h056e);
	endtask : t_io
	task automatic t_table();
		wreg(5'h1e, 8'h34);
		wreg(5'h1f, 8'h12);
		tbl = 1;
		@(negedge clk);
		tbl = 0;
		chk({15'h0000, tgrant}, 16'h0001);
		chk({2'h0, faddr}, 16'h1234);
		@(negedge clk);
	endtask : t_table
	// Stack set up first; an unset pointer would push into the register file
	task automatic t_call();
		mop(1, M_DIRECT, 0, 0, 16'h005d, 8'h5f);
		mop(1, M_DIRECT, 0, 0, 16'h005e, 8'h04);
		mop(0, M_DIRECT, 0, 0, 16'h005e, 0);
		chk(got, 16'h0004);
		sreq = 1;
		@(negedge clk);
		sreq = 0;
		chk({14'h0000, sgrant, deny}, 16'h0001);
		pc0 = paddr;
		creq = 1;
		ctgt = 13'h1f80;
		@(negedge clk);
		creq = 0;
		chk({15'h0000, busy}, 16'h0001);
		repeat (2) @(negedge clk);
		chk({2'h0, paddr, busy}, 16'h3f00);
		mop(0, M_DIRECT, 0, 0, 16'h045f, 0);
		chk(got, {8'h00, pc0[7:0]});
		mop(0, M_DIRECT, 0, 0, 16'h045e, 0);
		chk(got, {11'h000, pc0[12:8]});
		mop(0, M_DIRECT, 0, 0, 16'h005d, 0);
		chk(got, 16'h005d);
		sreq = 1;
		@(negedge clk);
		sreq = 0;
		chk({14'h0000, sgrant, deny}, 16'h0002);
		rreq = 1;
		@(negedge clk);
		rreq = 0;
		repeat (2) @(negedge clk);
		chk({3'h0, paddr}, {3'h0, pc0});
	endtask : t_call
	// Gate closed first, then two pending requests with the gate open
	task automatic t_irq();
		irq = 8'h0c;
		@(negedge clk);
		irq = 8'h00;
		chk({ack, 7'h00, busy}, 16'h0000);
		mop(1, M_DIRECT, 0, 0, 16'h005f, 8'h80);
		chk({15'h0000, gie}, 16'h0001);
		pc0 = paddr;
		irq = 8'h0c;
		@(negedge clk);
		irq = 8'h00;
		chk({ack, 7'h00, gie}, 16'h0400);
		repeat (2) @(negedge clk);
		chk({3'h0, paddr}, 16'h0004);
		rreq = 1;
		@(negedge clk);
		rreq = 0;
		repeat (2) @(negedge clk);
		chk({3'h0, paddr}, {3'h0, pc0 - 13'h0001});
	endtask : t_irq
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge clk);
		arst_n = 1;
		t_fetch();
		t_regs();
		t_ptr();
		t_edges();
		t_io();
		t_table();
		t_call();
		t_irq();
		stop_test();
	end
endmodule : cpu_regfile_and_data_map_bench
